//--- pgei_map.vh
// Register map and field constants for the event pin and interrupt register slice
`ifndef PGEI_MAP_VH
`define PGEI_MAP_VH

`define PGEI_ADDR_W            12
`define PGEI_OFF_STAMP_LOW     12'h650
`define PGEI_OFF_STAMP_HIGH    12'h652
`define PGEI_OFF_PIN_MON       12'h680
`define PGEI_OFF_PIN_DIR       12'h682
`define PGEI_OFF_TRIG_IS       12'h688
`define PGEI_OFF_TRIG_IE       12'h68A
`define PGEI_OFF_STAMP_IS      12'h68C
`define PGEI_OFF_STAMP_IE      12'h68E

`define PGEI_RST_16            16'h0000
`define PGEI_RST_14            14'h0000
`define PGEI_RST_12            12'h000
`define PGEI_RST_7             7'h00
`define PGEI_RST_2             2'h0
`define PGEI_RST_1             1'h0

`define PGEI_NPIN              7
`define PGEI_NUNIT             12
`define PGEI_STAMP_W           14

`define PGEI_NS_LO_MSB         15
`define PGEI_NS_HI_MSB         29
`define PGEI_NS_HI_LSB         16
`define PGEI_SEC_LSB_W         2

`define PGEI_STAMP_BIT_DLY     13
`define PGEI_STAMP_BIT_SYNC    12

`define PGEI_TOP_TRIG_BIT      10
`define PGEI_TOP_STAMP_BIT     12
`define PGEI_TOP_W             16

`endif

//--- pgei_regs.v
// Event pin, egress stamp and interrupt register slice of the precision-time unit
//
// Summary of operation
// - Stamp high word bits 15:14 show egress seconds bits 1:0.
// - Pin monitor returns live level of pins 6..0 on bits 6..0.
// - Direction bit 0 makes trigger output, 1 makes stamp input; reset zero.
// - Trigger unit done or error sets its status bit; units 12..1 on 11..0.
// - Trigger status clears only on software write of one.
// - OR of trigger status drives top status bit 10.
// - Delay-type egress stamp available sets stamp status bit 13.
// - Sync egress stamp available sets stamp status bit 12.
// - Stamp input unit ready sets its status bit; units 12..1 on 11..0.
// - OR of all stamp status bits drives top status bit 12.
// - Stamp status bits clear on software write of one.
// - Stamp enables in matching positions, ORed, drive top enable bit 12.
// - Low word holds egress nanoseconds bits 15:0.
`timescale 1ns/1ps
`default_nettype none
`include "pgei_map.vh"

module pgei_regs (
    // Clock and reset
    input  wire                        clk,
    input  wire                        reset,
    // Host register port
    input  wire [`PGEI_ADDR_W-1:0]     reg_addr,
    input  wire                        reg_wr,
    input  wire                        reg_rd,
    input  wire [15:0]                 reg_wdata,
    output reg  [15:0]                 reg_rdata,
    // Event pins
    input  wire [`PGEI_NPIN-1:0]       event_pin_in,
    output reg  [`PGEI_NPIN-1:0]       pin_direction_select,
    // Unit events
    input  wire [`PGEI_NUNIT-1:0]      trig_unit_event,
    input  wire [`PGEI_NUNIT-1:0]      stamp_unit_ready,
    input  wire                        dly_stamp_avail,
    input  wire                        sync_stamp_avail,
    // Pdelay response egress capture
    input  wire                        pdelay_resp_capture,
    input  wire [`PGEI_NS_HI_MSB:0]    pdelay_resp_ns,
    input  wire [`PGEI_SEC_LSB_W-1:0]  pdelay_resp_sec,
    // Top-level interrupt contributions
    output reg                         top_irq_status_trig,
    output reg                         top_irq_status_stamp,
    output reg                         top_irq_enable_trig,
    output reg                         top_irq_enable_stamp
);

    reg  [15:0]                 stamp_low_q;
    reg  [`PGEI_STAMP_W-1:0]    stamp_ns_hi_q;
    reg  [`PGEI_SEC_LSB_W-1:0]  stamp_sec_q;
    reg  [`PGEI_NPIN-1:0]       pin_mon_q;
    reg  [`PGEI_NUNIT-1:0]      trig_is_q;
    reg  [`PGEI_NUNIT-1:0]      trig_ie_q;
    reg  [`PGEI_NUNIT+1:0]      stamp_is_q;
    reg  [`PGEI_NUNIT+1:0]      stamp_ie_q;
    reg  [15:0]                 rdata_d;
    wire [`PGEI_NUNIT+1:0]      stamp_set;
    wire [`PGEI_NUNIT+1:0]      stamp_is_d;
    wire [`PGEI_NUNIT-1:0]      trig_is_d;
    wire [`PGEI_NUNIT-1:0]      trig_clr;
    wire [`PGEI_NUNIT+1:0]      stamp_clr;
    wire                        dly_set;
    genvar                      gi;

    function wr_hit;
        input [`PGEI_ADDR_W-1:0] off;
        begin
            wr_hit = reg_wr && (reg_addr == off);
        end
    endfunction

    // Next value of one sticky flag; the event term is ORed last so it wins
    function flag_next;
        input set;
        input cur;
        input clr;
        begin
            flag_next = set | (cur & ~clr);
        end
    endfunction

    // Capture raises the delay-type flag together with the words
    assign dly_set = dly_stamp_avail | pdelay_resp_capture;

    assign stamp_set = {dly_set, sync_stamp_avail, stamp_unit_ready};

    assign trig_clr = wr_hit(`PGEI_OFF_TRIG_IS) ? reg_wdata[`PGEI_NUNIT-1:0] : `PGEI_RST_12;
    assign stamp_clr = wr_hit(`PGEI_OFF_STAMP_IS) ? reg_wdata[`PGEI_NUNIT+1:0] : {`PGEI_RST_2, `PGEI_RST_12};

    // Per-bit flags keep each unit independent of the others
    generate
        for (gi = 0; gi < `PGEI_NUNIT; gi = gi + 1) begin : g_trig_flag
            assign trig_is_d[gi] = flag_next(trig_unit_event[gi], trig_is_q[gi], trig_clr[gi]);
        end
        for (gi = 0; gi < `PGEI_NUNIT + 2; gi = gi + 1) begin : g_stamp_flag
            assign stamp_is_d[gi] = flag_next(stamp_set[gi], stamp_is_q[gi], stamp_clr[gi]);
        end
    endgenerate

    // Egress stamp words; a capture beats a host write in the same cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stamp_low_q   <= `PGEI_RST_16;
            stamp_ns_hi_q <= `PGEI_RST_14;
            stamp_sec_q   <= `PGEI_RST_2;
        end else begin
            if (pdelay_resp_capture) begin
                stamp_low_q   <= pdelay_resp_ns[`PGEI_NS_LO_MSB:0];
                stamp_ns_hi_q <= pdelay_resp_ns[`PGEI_NS_HI_MSB:`PGEI_NS_HI_LSB];
                stamp_sec_q   <= pdelay_resp_sec;
            end else begin
                if (wr_hit(`PGEI_OFF_STAMP_LOW)) begin
                    stamp_low_q <= reg_wdata;
                end
                if (wr_hit(`PGEI_OFF_STAMP_HIGH)) begin
                    stamp_ns_hi_q <= reg_wdata[`PGEI_STAMP_W-1:0];
                    stamp_sec_q   <= reg_wdata[`PGEI_TOP_W-1:`PGEI_STAMP_W];
                end
            end
        end
    end

    // Pin sample and configuration bits
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_mon_q            <= `PGEI_RST_7;
            pin_direction_select <= `PGEI_RST_7;
            trig_ie_q            <= `PGEI_RST_12;
            stamp_ie_q           <= {`PGEI_RST_2, `PGEI_RST_12};
        end else begin
            // Live pin sample
            // One cycle of latency keeps the read mux off the raw pins
            pin_mon_q <= event_pin_in;
            if (wr_hit(`PGEI_OFF_PIN_DIR)) begin
                pin_direction_select <= reg_wdata[`PGEI_NPIN-1:0];
            end
            if (wr_hit(`PGEI_OFF_TRIG_IE)) begin
                trig_ie_q <= reg_wdata[`PGEI_NUNIT-1:0];
            end
            if (wr_hit(`PGEI_OFF_STAMP_IE)) begin
                stamp_ie_q <= reg_wdata[`PGEI_NUNIT+1:0];
            end
        end
    end

    // Sticky status flags
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            trig_is_q  <= `PGEI_RST_12;
            stamp_is_q <= {`PGEI_RST_2, `PGEI_RST_12};
        end else begin
            trig_is_q  <= trig_is_d;
            stamp_is_q <= stamp_is_d;
        end
    end

    // Summaries are registered from next-state so they track status in the same cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            top_irq_status_trig  <= `PGEI_RST_1;
            top_irq_status_stamp <= `PGEI_RST_1;
            top_irq_enable_trig  <= `PGEI_RST_1;
            top_irq_enable_stamp <= `PGEI_RST_1;
        end else begin
            top_irq_status_trig  <= |trig_is_d;
            top_irq_status_stamp <= |stamp_is_d;
            top_irq_enable_trig  <= wr_hit(`PGEI_OFF_TRIG_IE) ? |reg_wdata[`PGEI_NUNIT-1:0] : |trig_ie_q;
            top_irq_enable_stamp <= wr_hit(`PGEI_OFF_STAMP_IE) ? |reg_wdata[`PGEI_NUNIT+1:0] : |stamp_ie_q;
        end
    end

    always @* begin
        rdata_d = `PGEI_RST_16;
        case (reg_addr)
            `PGEI_OFF_STAMP_LOW:  rdata_d = stamp_low_q;
            `PGEI_OFF_STAMP_HIGH: rdata_d = {stamp_sec_q, stamp_ns_hi_q};
            `PGEI_OFF_PIN_MON:    rdata_d[`PGEI_NPIN-1:0] = pin_mon_q;
            `PGEI_OFF_PIN_DIR:    rdata_d[`PGEI_NPIN-1:0] = pin_direction_select;
            `PGEI_OFF_TRIG_IS:    rdata_d[`PGEI_NUNIT-1:0] = trig_is_q;
            `PGEI_OFF_TRIG_IE:    rdata_d[`PGEI_NUNIT-1:0] = trig_ie_q;
            `PGEI_OFF_STAMP_IS:   rdata_d[`PGEI_NUNIT+1:0] = stamp_is_q;
            `PGEI_OFF_STAMP_IE:   rdata_d[`PGEI_NUNIT+1:0] = stamp_ie_q;
            default:              rdata_d = `PGEI_RST_16;
        endcase
    end

    // Read data is held between reads so the host can sample late
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `PGEI_RST_16;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

endmodule // pgei_regs

`default_nettype wire

//--- pgei_regs_props.sv
// Checker for the event pin and interrupt register slice
`timescale 1ns/1ps
`default_nettype none
module pgei_regs_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Host port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Pins and events
    input wire logic [6:0]  event_pin_in,
    input wire logic [6:0]  pin_direction_select,
    input wire logic [11:0] trig_unit_event,
    input wire logic [11:0] stamp_unit_ready,
    input wire logic        dly_stamp_avail,
    input wire logic        sync_stamp_avail,
    input wire logic        pdelay_resp_capture,
    input wire logic [29:0] pdelay_resp_ns,
    input wire logic [1:0]  pdelay_resp_sec,
    // Top-level bits
    input wire logic        top_irq_status_trig,
    input wire logic        top_irq_status_stamp,
    input wire logic        top_irq_enable_trig,
    input wire logic        top_irq_enable_stamp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_trig_set; |trig_unit_event |=> top_irq_status_trig; endproperty
    a_trig_set: assert property (p_trig_set) else $error("trigger event lost");
    property p_trig_hold; top_irq_status_trig && !(reg_wr && reg_addr == 12'h688) |=> top_irq_status_trig; endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("trigger status dropped");
    property p_stamp_set; |{stamp_unit_ready, dly_stamp_avail, sync_stamp_avail, pdelay_resp_capture}
        |=> top_irq_status_stamp; endproperty
    a_stamp_set: assert property (p_stamp_set) else $error("stamp event lost");
    property p_stamp_hold; top_irq_status_stamp && !(reg_wr && reg_addr == 12'h68C) |=> top_irq_status_stamp; endproperty
    a_stamp_hold: assert property (p_stamp_hold) else $error("stamp status dropped");
    property p_dir; reg_wr && reg_addr == 12'h682 |=> pin_direction_select == $past(reg_wdata[6:0]); endproperty
    a_dir: assert property (p_dir) else $error("direction not written");
    property p_trig_en; reg_wr && reg_addr == 12'h68A |=> top_irq_enable_trig == |$past(reg_wdata[11:0]); endproperty
    a_trig_en: assert property (p_trig_en) else $error("trigger enable OR wrong");
    property p_stamp_en; reg_wr && reg_addr == 12'h68E |=> top_irq_enable_stamp == |$past(reg_wdata[13:0]); endproperty
    a_stamp_en: assert property (p_stamp_en) else $error("stamp enable OR wrong");
    property p_hi; pdelay_resp_capture ##1 (reg_rd && !reg_wr && reg_addr == 12'h652)
        |=> reg_rdata == {$past(pdelay_resp_sec, 2), $past(pdelay_resp_ns[29:16], 2)}; endproperty
    a_hi: assert property (p_hi) else $error("stale high stamp word");
endmodule // pgei_regs_props
bind pgei_regs pgei_regs_props u_props (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_pin_in(event_pin_in),
    .pin_direction_select(pin_direction_select), .trig_unit_event(trig_unit_event),
    .stamp_unit_ready(stamp_unit_ready), .dly_stamp_avail(dly_stamp_avail),
    .sync_stamp_avail(sync_stamp_avail), .pdelay_resp_capture(pdelay_resp_capture),
    .pdelay_resp_ns(pdelay_resp_ns), .pdelay_resp_sec(pdelay_resp_sec),
    .top_irq_status_trig(top_irq_status_trig), .top_irq_status_stamp(top_irq_status_stamp),
    .top_irq_enable_trig(top_irq_enable_trig), .top_irq_enable_stamp(top_irq_enable_stamp)
);
`default_nettype wire

//--- tb_ptp_gpio_event_irq_regs.sv
// Self-checking bench for the event pin and interrupt register slice
`timescale 1ns/1ps
`default_nettype none
module tb_ptp_gpio_event_irq_regs;
    logic        clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, dly_stamp_avail = 0, sync_stamp_avail = 0;
    logic        pdelay_resp_capture = 0, top_irq_status_trig, top_irq_status_stamp;
    logic        top_irq_enable_trig, top_irq_enable_stamp;
    logic [11:0] reg_addr = 0, trig_unit_event = 0, stamp_unit_ready = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, v;
    logic [6:0]  event_pin_in = 0, pin_direction_select;
    logic [29:0] pdelay_resp_ns = 0;
    logic [1:0]  pdelay_resp_sec = 0;
    logic [11:0] ad [9] = '{12'h650, 12'h652, 12'h654, 12'h680, 12'h682, 12'h688, 12'h68A, 12'h68C, 12'h68E};
    int          failures = 0, samples_checked = 0;
    pgei_regs dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_pin_in(event_pin_in),
        .pin_direction_select(pin_direction_select), .trig_unit_event(trig_unit_event),
        .stamp_unit_ready(stamp_unit_ready), .dly_stamp_avail(dly_stamp_avail),
        .sync_stamp_avail(sync_stamp_avail), .pdelay_resp_capture(pdelay_resp_capture),
        .pdelay_resp_ns(pdelay_resp_ns), .pdelay_resp_sec(pdelay_resp_sec),
        .top_irq_status_trig(top_irq_status_trig), .top_irq_status_stamp(top_irq_status_stamp),
        .top_irq_enable_trig(top_irq_enable_trig), .top_irq_enable_stamp(top_irq_enable_stamp)
    );
    initial forever #5 clk = ~clk;
    task chk(input string n, input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 0;
    endtask
    task rc(input logic [11:0] a, input logic [15:0] e, input string n);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 0;
        @(posedge clk) #1 chk(n, reg_rdata, e);
    endtask
    task complete_run;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task t_regs;
        foreach (ad[i]) rc(ad[i], 16'h0, "reset");
        chk("top_rst", {top_irq_status_trig, top_irq_status_stamp, top_irq_enable_trig, top_irq_enable_stamp}, 16'h0);
        @(posedge clk) event_pin_in <= 7'h5A;
        wr(12'h680, 16'hFFFF);
        rc(12'h680, 16'h005A, "monitor");
        wr(12'h682, 16'hFFFF);
        rc(12'h682, 16'h007F, "dir");
        chk("dir_out", pin_direction_select, 16'h7F);
        $display("test regs done");
    endtask
    task t_trig;
        @(posedge clk) trig_unit_event <= 12'h801;
        @(posedge clk) {reg_addr, reg_wdata, reg_wr, trig_unit_event} <= {12'h688, 16'hF801, 1'b1, 12'h800};
        @(posedge clk) {reg_wr, trig_unit_event} <= 0;
        rc(12'h688, 16'h0800, "trig_w1c");
        chk("trig_top", top_irq_status_trig, 16'h1);
        wr(12'h688, 16'h07FF);
        rc(12'h688, 16'h0800, "trig_keep");
        wr(12'h688, 16'h0800);
        rc(12'h688, 16'h0, "trig_clr");
        chk("trig_top0", top_irq_status_trig, 16'h0);
        wr(12'h68A, 16'hF001);
        rc(12'h68A, 16'h0001, "trig_en");
        chk("trig_en_top", top_irq_enable_trig, 16'h1);
        $display("test trig done");
    endtask
    task t_stamp;
        @(posedge clk) {stamp_unit_ready, dly_stamp_avail, sync_stamp_avail} <= {12'h008, 2'b11};
        @(posedge clk) {stamp_unit_ready, dly_stamp_avail, sync_stamp_avail} <= 0;
        rc(12'h68C, 16'h3008, "stamp_is");
        chk("stamp_top", top_irq_status_stamp, 16'h1);
        wr(12'h68C, 16'h1008);
        rc(12'h68C, 16'h2000, "stamp_w1c");
        chk("stamp_top1", top_irq_status_stamp, 16'h1);
        wr(12'h68E, 16'hFFFF);
        rc(12'h68E, 16'h3FFF, "stamp_en");
        chk("stamp_en_top", top_irq_enable_stamp, 16'h1);
        $display("test stamp done");
    endtask
    task t_cap;
        wr(12'h68C, 16'h3FFF);
        @(posedge clk) {pdelay_resp_capture, pdelay_resp_ns, pdelay_resp_sec} <= {1'b1, 30'h2ABC1234, 2'h3};
        @(posedge clk) {pdelay_resp_capture, reg_addr, reg_rd} <= {1'b0, 12'h652, 1'b1};
        @(posedge clk) reg_rd <= 0;
        @(posedge clk) #1 chk("stamp_high", reg_rdata, 16'hEABC);
        chk("cap_top", top_irq_status_stamp, 16'h1);
        rc(12'h650, 16'h1234, "stamp_low");
        rc(12'h68C, 16'h2000, "cap_flag");
        $display("test capture done");
    endtask
    task t_reset;
        @(posedge clk) reset <= 1;
        repeat (4) @(posedge clk);
        reset <= 0;
        rc(12'h682, 16'h0, "dir_rst");
        rc(12'h68C, 16'h0, "is_rst");
        chk("top_rst2", {top_irq_status_trig, top_irq_status_stamp, top_irq_enable_trig, top_irq_enable_stamp}, 16'h0);
        $display("test reset done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 0;
        t_regs;
        t_trig;
        t_stamp;
        t_cap;
        t_reset;
        complete_run;
    end
    initial begin
        #50000;
        failures++;
        complete_run;
    end
endmodule // tb_ptp_gpio_event_irq_regs
`default_nettype wire
